//--- design/dee_ctrl.sv
// Register-level control of byte reads and writes to the data EEPROM.
//
// How it works
// - Access acts only with both space selects clear.
// - Read trigger loads addressed byte, ready next access.
// - Data register holds until next read or write.
// - Write needs 55h then AAh then trigger.
// - Write trigger refused unless enable already set.
// - Enable and trigger together never start writes.
// - Hardware never clears the write enable bit.
// - Control, address frozen during write cycle; data too, unless read trigger set with it.
// - Write end clears trigger, sets complete flag.
// - Complete flag cleared by software only.
// - Array holds 1024 bytes, ten address bits.
//
// Added by the designer: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module dee_ctrl #(
  parameter int unsigned DEPTH = dee_pkg::MEM_DEPTH
) (
  // Clock and reset.
  input  wire logic                       clk,
  input  wire logic                       resetn,
  // Avalon-MM slave.
  input  wire logic [dee_pkg::BUS_AW-1:0] avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [3:0]                 avs_byteenable,
  input  wire logic [dee_pkg::BUS_DW-1:0] avs_writedata,
  output logic [dee_pkg::BUS_DW-1:0]      avs_readdata,
  output logic                            avs_waitrequest,
  // Interrupt.
  output logic                            irq
);

  ////////////////////////////////////////////////////////////////////////
  // Register state.
  logic [1:0]                addr_high_ff;
  logic [7:0]                addr_low_ff;
  logic [7:0]                data_ff;
  logic                      prog_sel_ff;
  logic                      cfg_sel_ff;
  logic                      write_enable_bit_ff;
  logic                      wr_ff;
  logic                      stat_ff;
  logic                      mask_ff;
  dee_pkg::dee_unlock_e      ulk_ff;
  dee_pkg::dee_unlock_e      nxt_ulk;
  logic [dee_pkg::PROG_CW-1:0] prog_cnt_ff;
  logic                      rd_pend_ff;
  logic                      rvalid_ff;
  logic [dee_pkg::BUS_DW-1:0] readdata_ff;

  // Decoded bus events.
  logic                      wr_take;
  logic                      wr_low;
  logic                      rd_take;
  logic [7:0]                wbyte;
  logic                      ctrl_wr;
  logic                      rd_start;
  logic                      wr_start;
  logic                      key_ok;
  logic                      prog_done;
  logic [7:0]                mem_rdata;
  dee_pkg::dee_mem_req_s     mem_req;

  // True when the bus address selects the given register.
  function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
    hit = (a == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Bus handshake: reads wait one cycle for registered data, and every
  // access waits while an array read is loading the data register, so
  // the byte is always in place before the next access can see it.
  assign avs_waitrequest = rd_pend_ff | (avs_read & ~rvalid_ff);
  assign avs_readdata    = readdata_ff;
  assign wr_take = avs_write & ~avs_waitrequest;
  assign wr_low  = wr_take & avs_byteenable[0];
  assign rd_take = avs_read & ~avs_waitrequest;
  assign wbyte   = avs_writedata[7:0];

  // Writes to the control register are dropped during a write cycle.
  assign ctrl_wr = wr_low & hit(avs_address, dee_pkg::OFF_CTRL)
                   & ~wr_ff;

  // A read starts only with both space selects cleared.
  assign rd_start = ctrl_wr & wbyte[dee_pkg::BIT_RD]
                    & ~wbyte[dee_pkg::BIT_PROG_SEL]
                    & ~wbyte[dee_pkg::BIT_CFG_SEL];

  // A write starts only when armed and the enable was set earlier.
  assign wr_start = ctrl_wr & wbyte[dee_pkg::BIT_WR]
                    & (ulk_ff == dee_pkg::ULK_ARMED)
                    & write_enable_bit_ff
                    & ~wbyte[dee_pkg::BIT_PROG_SEL]
                    & ~wbyte[dee_pkg::BIT_CFG_SEL];

  assign prog_done = wr_ff & (prog_cnt_ff == '0);

  ////////////////////////////////////////////////////////////////////////
  // Read data register; rvalid gives each read one wait cycle, two if it arrives while an array read is loading.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= avs_read & ~rvalid_ff & ~rd_pend_ff;
    end
  end

  // Read multiplexer; unmapped addresses and reserved bits read zero.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      readdata_ff <= '0;
    end else if (avs_read & ~rvalid_ff & ~rd_pend_ff) begin
      readdata_ff <= '0;
      case (avs_address)
        dee_pkg::OFF_ADDR_HIGH: readdata_ff[1:0] <= addr_high_ff;
        dee_pkg::OFF_ADDR_LOW:  readdata_ff[7:0] <= addr_low_ff;
        dee_pkg::OFF_DATA:      readdata_ff[7:0] <= data_ff;
        dee_pkg::OFF_CTRL: begin
          readdata_ff[dee_pkg::BIT_PROG_SEL] <= prog_sel_ff;
          readdata_ff[dee_pkg::BIT_CFG_SEL]  <= cfg_sel_ff;
          readdata_ff[dee_pkg::BIT_WRITE_ENABLE_BIT]     <= write_enable_bit_ff;
          readdata_ff[dee_pkg::BIT_WR]       <= wr_ff;
        end
        dee_pkg::OFF_IRQ_STAT:
          readdata_ff[dee_pkg::BIT_WC_FLAG] <= stat_ff;
        dee_pkg::OFF_IRQ_MASK:
          readdata_ff[dee_pkg::BIT_WC_FLAG] <= mask_ff;
        default: readdata_ff <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Address pair; ten bits select one of the array's bytes.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      addr_high_ff <= dee_pkg::RST_ADDR_HI;
      addr_low_ff  <= dee_pkg::RST_BYTE;
    end else if (wr_low & ~wr_ff) begin
      if (hit(avs_address, dee_pkg::OFF_ADDR_HIGH)) begin
        addr_high_ff <= wbyte[1:0];
      end
      if (hit(avs_address, dee_pkg::OFF_ADDR_LOW)) begin
        addr_low_ff <= wbyte;
      end
    end
  end

  // Data register: loaded by an array read or by software only.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      data_ff <= dee_pkg::RST_BYTE;
    end else if (rd_pend_ff) begin
      data_ff <= mem_rdata;
    end else if (wr_low & ~wr_ff
                 & hit(avs_address, dee_pkg::OFF_DATA)) begin
      data_ff <= wbyte;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control bits; the enable is changed by software writes alone.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      prog_sel_ff <= dee_pkg::RST_BIT;
      cfg_sel_ff  <= dee_pkg::RST_BIT;
      write_enable_bit_ff     <= dee_pkg::RST_BIT;
    end else if (ctrl_wr) begin
      prog_sel_ff <= wbyte[dee_pkg::BIT_PROG_SEL];
      cfg_sel_ff  <= wbyte[dee_pkg::BIT_CFG_SEL];
      write_enable_bit_ff     <= wbyte[dee_pkg::BIT_WRITE_ENABLE_BIT];
    end
  end

  // Read strobe: one cycle of array access, then the byte is loaded.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rd_pend_ff <= 1'b0;
    end else begin
      rd_pend_ff <= rd_start;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write cycle: the trigger bit doubles as a busy flag for polling and
  // is cleared by hardware only when the programming time is over.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_ff       <= dee_pkg::RST_BIT;
      prog_cnt_ff <= '0;
    end else if (wr_start) begin
      wr_ff       <= 1'b1;
      prog_cnt_ff <= dee_pkg::PROG_CW'(dee_pkg::PROG_CYCLES - 1);
    end else if (prog_done) begin
      wr_ff <= 1'b0;
    end else if (wr_ff) begin
      prog_cnt_ff <= prog_cnt_ff - 1'b1;
    end
  end

  // Array access: the byte is committed when the cycle starts.
  always_comb begin
    mem_req       = '0;
    mem_req.we    = wr_start;
    mem_req.addr  = {addr_high_ff, addr_low_ff};
    mem_req.wdata = data_ff;
  end

  dee_mem #(
    .DEPTH (DEPTH)
  ) u_mem (
    .clk   (clk),
    .req   (mem_req),
    .rdata (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // Unlock tracker. Any write that is not the next step sends it back,
  // so stray code between the keys cannot leave the block armed.
  always_comb begin
    key_ok  = 1'b0;
    nxt_ulk = ulk_ff;
    if (wr_take) begin
      nxt_ulk = dee_pkg::ULK_IDLE;
      if (hit(avs_address, dee_pkg::OFF_UNLOCK) & avs_byteenable[0]) begin
        case (ulk_ff)
          dee_pkg::ULK_IDLE: begin
            key_ok = (wbyte == dee_pkg::UNLOCK_KEY1);
            if (key_ok) begin
              nxt_ulk = dee_pkg::ULK_GOT1;
            end
          end
          dee_pkg::ULK_GOT1: begin
            key_ok = (wbyte == dee_pkg::UNLOCK_KEY2);
            if (key_ok) begin
              nxt_ulk = dee_pkg::ULK_ARMED;
            end
          end
          default: nxt_ulk = dee_pkg::ULK_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ulk_ff <= dee_pkg::ULK_IDLE;
    end else begin
      ulk_ff <= nxt_ulk;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status: a finished write sets the flag, a read of the
  // status register clears it, and a set in the same cycle wins.
  // Only a read that returned the flag clears it, so a write that ends
  // while the read waits for its data is never lost.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      stat_ff <= dee_pkg::RST_BIT;
    end else if (prog_done) begin
      stat_ff <= 1'b1;
    end else if (rd_take & hit(avs_address, dee_pkg::OFF_IRQ_STAT)
                 & readdata_ff[dee_pkg::BIT_WC_FLAG]) begin
      stat_ff <= 1'b0;
    end
  end

  // Mask register, software owned.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mask_ff <= dee_pkg::RST_BIT;
    end else if (wr_low & hit(avs_address, dee_pkg::OFF_IRQ_MASK)) begin
      mask_ff <= wbyte[dee_pkg::BIT_WC_FLAG];
    end
  end

  // Level interrupt while the unmasked flag stands.
  assign irq = stat_ff & mask_ff;

  ////////////////////////////////////////////////////////////////////////
  // Helper for checks: length of the current write cycle.
  logic [dee_pkg::PROG_CW-1:0] busy_len_ff;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      busy_len_ff <= '0;
    end else if (wr_start) begin
      busy_len_ff <= '0;
    end else if (wr_ff) begin
      busy_len_ff <= busy_len_ff + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks.
  read_fetch_a: assert property (
    @(posedge clk) disable iff (!resetn)
    rd_start |=> rd_pend_ff ##1 (data_ff == $past(mem_rdata)))
    else $error("array read did not reach the data register");

  read_select_a: assert property (
    @(posedge clk) disable iff (!resetn)
    $rose(rd_pend_ff) |->
      !$past(wbyte[dee_pkg::BIT_PROG_SEL])
      && !$past(wbyte[dee_pkg::BIT_CFG_SEL]))
    else $error("read started with a space select set");

  data_hold_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (!rd_pend_ff && !(wr_low && hit(avs_address, dee_pkg::OFF_DATA)))
      |=> $stable(data_ff))
    else $error("data register changed without a cause");

  unlock_order_a: assert property (
    @(posedge clk) disable iff (!resetn)
    $rose(wr_ff) |-> $past(ulk_ff) == dee_pkg::ULK_ARMED)
    else $error("write started without the unlock keys");

  enable_first_a: assert property (
    @(posedge clk) disable iff (!resetn)
    $rose(wr_ff) |-> $past(write_enable_bit_ff) && $past(ctrl_wr))
    else $error("write started without prior enable");

  enable_keep_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (write_enable_bit_ff && !ctrl_wr) |=> write_enable_bit_ff)
    else $error("write enable cleared by hardware");

  busy_lock_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (wr_ff && !rd_pend_ff) |=> $stable(addr_low_ff)
      && $stable(addr_high_ff) && $stable(data_ff) && $stable(write_enable_bit_ff))
    else $error("registers changed during a write cycle");

  write_end_a: assert property (
    @(posedge clk) disable iff (!resetn)
    $fell(wr_ff) |-> stat_ff && busy_len_ff == dee_pkg::PROG_CYCLES)
    else $error("write cycle ended wrongly");

  flag_sticky_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (stat_ff && !(rd_take && hit(avs_address, dee_pkg::OFF_IRQ_STAT)
                  && readdata_ff[dee_pkg::BIT_WC_FLAG]))
      |=> stat_ff)
    else $error("complete flag cleared without a status read");

  unlock_reset_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (wr_take && !key_ok) |=> ulk_ff == dee_pkg::ULK_IDLE)
    else $error("unlock tracker kept state after a stray write");

endmodule
`default_nettype wire

//--- design/dee_mem.sv
// Byte array of the data EEPROM with registered read data.
`timescale 1ns/10ps
`default_nettype none
module dee_mem #(
  parameter int unsigned DEPTH = dee_pkg::MEM_DEPTH
) (
  // Clock.
  input  wire logic                 clk,
  // Access request and read data.
  input  wire dee_pkg::dee_mem_req_s req,
  output logic [7:0]                rdata
);

  logic [7:0] mem_ff [DEPTH];

  ////////////////////////////////////////////////////////////////////////
  // The array has no reset, as a real nonvolatile array keeps its bytes.
  always_ff @(posedge clk) begin
    if (req.we) begin
      mem_ff[req.addr] <= req.wdata;
    end
  end

  // Read data always come out of a register, one cycle after the request.
  always_ff @(posedge clk) begin
    rdata <= mem_ff[req.addr];
  end

endmodule
`default_nettype wire

//--- dv/dee_ctrl_test.sv
// Self-checking testbench for the data EEPROM access controller.
`timescale 1ns/10ps
`default_nettype none
module dee_ctrl_test;

  //////////////////////////////////////////////////////////////////////////
  // Bench signals and counters.
  logic                       clk;
  logic                       resetn;
  logic [dee_pkg::BUS_AW-1:0] avs_address;
  logic                       avs_read;
  logic                       avs_write;
  logic [3:0]                 avs_byteenable;
  logic [dee_pkg::BUS_DW-1:0] avs_writedata;
  logic [dee_pkg::BUS_DW-1:0] avs_readdata;
  logic                       avs_waitrequest;
  logic                       irq;
  logic [dee_pkg::BUS_DW-1:0] rd;
  int                         miscompares;
  int                         tests_run;
  int                         cyc;
  int                         t0;

  // Device under test.
  dee_ctrl i_dee_ctrl (
    .clk             (clk),
    .resetn          (resetn),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_byteenable  (avs_byteenable),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .irq             (irq)
  );

  // 25 MHz clock and a free cycle count for timing the write cycle.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  //////////////////////////////////////////////////////////////////////////
  // Comparison and verdict.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task print_verdict;
    if (miscompares == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Avalon master. A request starts just after a rising edge and is held
  // until the rising edge at which waitrequest is sampled low; that edge
  // takes the write or the read data, and only then is it released.
  // Only the watchdog ends a wait that never finishes.
  task automatic bus_wait;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    check(32'(n > 3), 32'h0);
  endtask

  task automatic bus_write(input logic [dee_pkg::BUS_AW-1:0] a,
                           input logic [7:0] d, input logic [3:0] be = 4'hF);
    @(posedge clk);
    avs_address    <= a;
    avs_writedata  <= {24'h000000, d};
    avs_byteenable <= be;
    avs_write      <= 1'b1;
    bus_wait();
    avs_write <= 1'b0;
  endtask

  task automatic bus_read(input logic [dee_pkg::BUS_AW-1:0] a,
                          output logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read    <= 1'b1;
    bus_wait();
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask

  task automatic rchk(input logic [dee_pkg::BUS_AW-1:0] a,
                      input logic [31:0] exp);
    logic [31:0] v;
    bus_read(a, v);
    check(v, exp);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Byte-level sequences.
  task automatic set_addr(input logic [9:0] a);
    bus_write(dee_pkg::OFF_ADDR_HIGH, {6'h00, a[9:8]});
    bus_write(dee_pkg::OFF_ADDR_LOW, a[7:0]);
  endtask

  // Full write; checks the busy window, the frozen registers and the end.
  task automatic prog(input logic [9:0] a, input logic [7:0] d);
    int n;
    int el;
    set_addr(a);
    bus_write(dee_pkg::OFF_DATA, d);
    bus_write(dee_pkg::OFF_CTRL, 8'h04);
    bus_write(dee_pkg::OFF_UNLOCK, 8'h55);
    bus_write(dee_pkg::OFF_UNLOCK, 8'hAA);
    bus_write(dee_pkg::OFF_CTRL, 8'h06);
    t0 = cyc;
    rchk(dee_pkg::OFF_CTRL, 32'h06);
    bus_write(dee_pkg::OFF_DATA, 8'h00);
    bus_write(dee_pkg::OFF_ADDR_LOW, 8'h00);
    bus_write(dee_pkg::OFF_CTRL, 8'h00);
    n = 0;
    do begin
      bus_read(dee_pkg::OFF_CTRL, rd);
      n++;
    end while (rd[1] !== 1'b0 && n < 100);
    el = cyc - t0;
    check(32'(el >= dee_pkg::PROG_CYCLES - 1), 32'h1);
    check(32'(el <= dee_pkg::PROG_CYCLES + 8), 32'h1);
    check(rd, 32'h04);
    rchk(dee_pkg::OFF_DATA, {24'h0, d});
    rchk(dee_pkg::OFF_ADDR_LOW, {24'h0, a[7:0]});
  endtask

  // Read trigger, then the byte must be in the data register.
  task automatic rd_byte(input logic [9:0] a, input logic [7:0] exp);
    set_addr(a);
    bus_write(dee_pkg::OFF_CTRL, 8'h01);
    rchk(dee_pkg::OFF_DATA, {24'h0, exp});
  endtask

  // An unlock attempt that must not start a write cycle.
  task automatic try_wr(input logic [7:0] pre, k1, k2, trig, exp,
                        input logic mid, input logic [3:0] be);
    bus_write(dee_pkg::OFF_CTRL, pre);
    bus_write(dee_pkg::OFF_UNLOCK, k1);
    if (mid) begin
      bus_write(dee_pkg::OFF_IRQ_MASK, 8'h00, be);
    end
    bus_write(dee_pkg::OFF_UNLOCK, k2);
    bus_write(dee_pkg::OFF_CTRL, trig);
    rchk(dee_pkg::OFF_CTRL, {24'h0, exp});
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    resetn         = 1'b0;
    avs_address    = '0;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_byteenable = 4'hF;
    avs_writedata  = '0;
    cyc            = 0;
    miscompares    = 0;
    tests_run      = 0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rchk(5'(i * 4), 32'h0);
    end
    check(irq, 1'b0);
    // Mask clear: completion flag sets but the interrupt stays low.
    prog(10'h3FF, 8'hA5);
    @(negedge clk);
    check(irq, 1'b0);
    rchk(dee_pkg::OFF_IRQ_STAT, 32'h1);
    rchk(dee_pkg::OFF_IRQ_STAT, 32'h0);
    bus_write(dee_pkg::OFF_IRQ_MASK, 8'h01);
    prog(10'h0FF, 8'h3C);
    repeat (20) @(negedge clk);
    check(irq, 1'b1);
    rchk(dee_pkg::OFF_IRQ_STAT, 32'h1);
    @(negedge clk);
    check(irq, 1'b0);
    // The unlock is spent by the first trigger; a bare second one fails.
    bus_write(dee_pkg::OFF_CTRL, 8'h06);
    rchk(dee_pkg::OFF_CTRL, 32'h04);
    // Ten address bits, distinct locations, read trigger reads back 0.
    rd_byte(10'h3FF, 8'hA5);
    rd_byte(10'h0FF, 8'h3C);
    rchk(dee_pkg::OFF_CTRL, 32'h0);
    bus_write(dee_pkg::OFF_ADDR_HIGH, 8'hFF);
    rchk(dee_pkg::OFF_ADDR_HIGH, 32'h3);
    // Data register holds a written value across unrelated writes.
    bus_write(dee_pkg::OFF_DATA, 8'h5A);
    bus_write(dee_pkg::OFF_ADDR_LOW, 8'h12);
    rchk(dee_pkg::OFF_DATA, 32'h5A);
    // Read trigger with a space select set is ignored.
    set_addr(10'h3FF);
    bus_write(dee_pkg::OFF_CTRL, 8'h81);
    rchk(dee_pkg::OFF_DATA, 32'h5A);
    bus_write(dee_pkg::OFF_CTRL, 8'h41);
    rchk(dee_pkg::OFF_DATA, 32'h5A);
    // Refused write starts: no enable, enable with trigger, space select,
    // interleaved writes, keys out of order.
    bus_write(dee_pkg::OFF_DATA, 8'h77);
    try_wr(8'h00, 8'h55, 8'hAA, 8'h06, 8'h04, 1'b0, 4'hF);
    try_wr(8'h00, 8'h55, 8'hAA, 8'h02, 8'h00, 1'b0, 4'hF);
    try_wr(8'h04, 8'h55, 8'hAA, 8'hC6, 8'hC4, 1'b0, 4'hF);
    try_wr(8'h04, 8'h55, 8'hAA, 8'h46, 8'h44, 1'b0, 4'hF);
    try_wr(8'h04, 8'h55, 8'hAA, 8'h06, 8'h04, 1'b1, 4'hF);
    try_wr(8'h04, 8'h55, 8'hAA, 8'h06, 8'h04, 1'b1, 4'h0);
    try_wr(8'h04, 8'hAA, 8'h55, 8'h06, 8'h04, 1'b0, 4'hF);
    rchk(dee_pkg::OFF_IRQ_STAT, 32'h0);
    rd_byte(10'h3FF, 8'hA5);
    // Unmapped places ignore writes and read as zero.
    bus_write(5'h1C, 8'hFF);
    rchk(5'h1C, 32'h0);
    print_verdict();
  end

  // Watchdog against a hung handshake.
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    print_verdict();
  end

endmodule
`default_nettype wire

//--- shared/dee_pkg.sv
// Constants, types and register map of the data EEPROM access controller.
`default_nettype none
package dee_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Sizes of the bus and of the byte array.
  localparam int unsigned BUS_AW    = 5;
  localparam int unsigned BUS_DW    = 32;
  localparam int unsigned MEM_AW    = 10;
  localparam int unsigned MEM_DEPTH = 1024;

  ////////////////////////////////////////////////////////////////////////
  // Byte addresses of the registers on the bus.
  localparam logic [4:0] OFF_ADDR_HIGH = 5'h00;
  localparam logic [4:0] OFF_ADDR_LOW  = 5'h04;
  localparam logic [4:0] OFF_DATA      = 5'h08;
  localparam logic [4:0] OFF_CTRL      = 5'h0C;
  localparam logic [4:0] OFF_UNLOCK    = 5'h10;
  localparam logic [4:0] OFF_IRQ_STAT  = 5'h14;
  localparam logic [4:0] OFF_IRQ_MASK  = 5'h18;

  ////////////////////////////////////////////////////////////////////////
  // Bit positions in nv_control_one and in the interrupt registers.
  localparam int unsigned BIT_PROG_SEL = 7;
  localparam int unsigned BIT_CFG_SEL  = 6;
  localparam int unsigned BIT_WRITE_ENABLE_BIT     = 2;
  localparam int unsigned BIT_WR       = 1;
  localparam int unsigned BIT_RD       = 0;
  localparam int unsigned BIT_WC_FLAG  = 0;

  ////////////////////////////////////////////////////////////////////////
  // Unlock keys and values after reset.
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [1:0] RST_ADDR_HI = 2'h0;
  localparam logic       RST_BIT     = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // Programming time of one byte, rounded up to whole clock cycles.
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned PROG_TIME_NS  = 4000;
  localparam int unsigned PROG_CYCLES   =
    (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PROG_CW       = $clog2(PROG_CYCLES + 1);

  ////////////////////////////////////////////////////////////////////////
  // Unlock tracker states, one-hot.
  typedef enum logic [2:0] {
    ULK_IDLE  = 3'b001,
    ULK_GOT1  = 3'b010,
    ULK_ARMED = 3'b100
  } dee_unlock_e;

  // One access to the byte array.
  typedef struct packed {
    logic              we;
    logic [MEM_AW-1:0] addr;
    logic [7:0]        wdata;
  } dee_mem_req_s;

endpackage
`default_nettype wire
